// ==== rtl/rpsj_params.svh ====
`ifndef RPSJ_PARAMS_SVH
`define RPSJ_PARAMS_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define RPSJ_DIST_W 16
`define RPSJ_AMP_W 16
`define RPSJ_TIME_W 16

// ----------------------------------------
// timing
// ----------------------------------------
// clock period in ps (200 MHz)
`define RPSJ_CLK_PERIOD_PS 5000
// unit of the maximum-time setting, in us
`define RPSJ_TICK_TIME_US 1000
// clock cycles per time unit
`define RPSJ_TICK_CYCLES ((`RPSJ_TICK_TIME_US * 1000 * 1000) / `RPSJ_CLK_PERIOD_PS)

// ----------------------------------------
// reset values
// ----------------------------------------
`define RPSJ_RANGE_MIN_RST 16'h0000
`define RPSJ_RANGE_MAX_RST 16'hFFFF

`endif

// ==== rtl/rpsj_pkg.sv ====
package rpsj_pkg;

	// ----------------------------------------
	// peak selection modes
	// ----------------------------------------
	typedef enum logic [2:0] {
		SEL_NEAREST,
		SEL_STRONGEST,
		SEL_RCS_MAX,
		SEL_FARTHEST,
		SEL_WEAKEST,
		SEL_RCS_MIN
	} rpsj_sel_type;

	// ----------------------------------------
	// jump filter states
	// ----------------------------------------
	typedef enum logic [1:0] {
		FLT_EMPTY,
		FLT_TRACK,
		FLT_HOLD
	} rpsj_flt_type;

endpackage

// ==== rtl/rpsj_meas_if.sv ====
`timescale 1ns/1ps

// selected distance per measurement cycle, selector to jump filter
interface rpsj_meas_if #(
	parameter int DIST_W = 16
);
	logic              measValid;  // one-cycle pulse, a target was selected
	logic [DIST_W-1:0] measDist;   // selected distance
	logic              measNone;   // one-cycle pulse, no target this cycle

	modport src (output measValid, output measDist, output measNone);
	modport dst (input measValid, input measDist, input measNone);
endinterface

// ==== rtl/rpsj_jump_filter.sv ====
`timescale 1ns/1ps
`include "rpsj_params.svh"

module rpsj_jump_filter #(
	parameter int DIST_W      = `RPSJ_DIST_W,
	parameter int TIME_W      = `RPSJ_TIME_W,
	parameter int TICK_CYCLES = `RPSJ_TICK_CYCLES
)(
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              nrst,
	// selected distance in
	rpsj_meas_if.dst               meas,
	// settings
	input  wire logic [DIST_W-1:0] maxJump,
	input  wire logic [TIME_W-1:0] maxTime,
	// distance out
	output logic                   distValid,
	output logic [DIST_W-1:0]      distOut,
	output logic                   noTarget,
	output logic                   filterActive
);

	localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [DIST_W-1:0] absDiff(input logic [DIST_W-1:0] a,
		input logic [DIST_W-1:0] b);
		absDiff = (a > b) ? (a - b) : (b - a);
	endfunction

	rpsj_pkg::rpsj_flt_type state;         // filter state
	rpsj_pkg::rpsj_flt_type next_state;
	logic [DIST_W-1:0]      held;          // last stable distance
	logic [TW-1:0]          tickCnt;       // time unit divider
	logic                   tick;          // one pulse per time unit
	logic [TIME_W-1:0]      timer;         // time units spent holding
	logic [DIST_W-1:0]      diff;
	logic                   bypass;
	logic                   jump;
	logic                   expired;
	logic                   passNew;       // output the new distance

	assign diff    = absDiff(meas.measDist, held);
	assign bypass  = (maxJump == '0);                           // R11
	assign jump    = diff > maxJump;                            // R12
	assign expired = (maxTime != '0) && (timer >= maxTime);     // R16
	assign filterActive = (state == rpsj_pkg::FLT_HOLD);

	// ----------------------------------------
	// next state on each selected distance
	// ----------------------------------------
	always_comb begin
		next_state = state;
		passNew    = 1'b1;
		case (state)
			rpsj_pkg::FLT_EMPTY: begin
				next_state = rpsj_pkg::FLT_TRACK;   // no reference yet
			end
			rpsj_pkg::FLT_TRACK: begin
				if (!bypass && jump) begin
					next_state = rpsj_pkg::FLT_HOLD;  // R12
					passNew    = 1'b0;                // R14
				end
			end
			rpsj_pkg::FLT_HOLD: begin
				if (bypass || !jump || expired) begin
					next_state = rpsj_pkg::FLT_TRACK; // R15 R16
				end else begin
					passNew = 1'b0;                   // R14
				end
			end
			default: begin
				next_state = rpsj_pkg::FLT_TRACK;
			end
		endcase
	end

	// ----------------------------------------
	// state and held distance
	// ----------------------------------------
	// a no-target cycle leaves everything as it was
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state <= rpsj_pkg::FLT_EMPTY;
			held  <= '0;
		end else if (meas.measValid) begin
			state <= next_state;
			if (passNew) begin
				held <= meas.measDist;      // R13
			end
		end
	end

	// ----------------------------------------
	// time unit divider, free running
	// ----------------------------------------
	// free running keeps it small; timeout resolution is one unit
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			tickCnt <= '0;
		end else if (tickCnt == TW'(TICK_CYCLES - 1)) begin
			tickCnt <= '0;
		end else begin
			tickCnt <= tickCnt + 1'b1;
		end
	end
	assign tick = (tickCnt == TW'(TICK_CYCLES - 1));

	// ----------------------------------------
	// hold timer
	// ----------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			timer <= '0;
		end else if (meas.measValid && next_state != rpsj_pkg::FLT_HOLD) begin
			timer <= '0;                    // R17
		end else if (meas.measValid && state != rpsj_pkg::FLT_HOLD) begin
			timer <= '0;                    // R17
		end else if (filterActive && tick && timer != '1) begin
			timer <= timer + 1'b1;          // saturates
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			distValid <= 1'b0;
			distOut   <= '0;
			noTarget  <= 1'b0;
		end else begin
			distValid <= meas.measValid;
			noTarget  <= meas.measNone;       // R18
			if (meas.measValid) begin
				distOut <= passNew ? meas.measDist : held;  // R14
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence jumpSeen;
		meas.measValid && state == rpsj_pkg::FLT_TRACK && !bypass && jump;
	endsequence

	sequence holdExpired;
		meas.measValid && filterActive && !bypass && jump && expired;
	endsequence

	chk_bypass_pass: assert property (@(posedge mclk) disable iff (!nrst) // R11
		meas.measValid && bypass |=> distValid && distOut == $past(meas.measDist) && !filterActive)
		else $error("disabled filter did not pass the distance");

	chk_jump_hold: assert property (@(posedge mclk) disable iff (!nrst) // R12
		jumpSeen |=> filterActive && distOut == $past(held))
		else $error("jump did not start holding");

	chk_small_pass: assert property (@(posedge mclk) disable iff (!nrst) // R13
		meas.measValid && state != rpsj_pkg::FLT_EMPTY && !jump
		|=> !filterActive && distOut == $past(meas.measDist))
		else $error("small change was not passed");

	chk_hold_stable: assert property (@(posedge mclk) disable iff (!nrst) // R14
		filterActive && !meas.measValid |=> $stable(held))
		else $error("held distance changed while holding");

	chk_timeout_pass: assert property (@(posedge mclk) disable iff (!nrst) // R16
		holdExpired |=> !filterActive && distOut == $past(meas.measDist) && timer == '0)
		else $error("timeout did not release the filter");

	chk_timer_clear: assert property (@(posedge mclk) disable iff (!nrst) // R17
		!filterActive |-> timer == '0)
		else $error("timer not cleared outside hold");

	chk_none_keeps: assert property (@(posedge mclk) disable iff (!nrst) // R18
		meas.measNone |=> $stable(state) && $stable(held) && noTarget && !distValid)
		else $error("no-target cycle disturbed the filter");

endmodule

// ==== rtl/radar_peak_select_jump_filter.sv ====
`timescale 1ns/1ps
`include "rpsj_params.svh"

// What this block does
// (R01) distance mode picks nearest in-window candidate
// (R02) amplitude mode picks strongest candidate
// (R03) normalized mode picks largest cross section
// (R04) reverse distance mode picks farthest candidate
// (R05) reverse amplitude mode picks weakest candidate
// (R06) reverse normalized picks smallest cross section
// (R07) new window limits act only on apply
// (R08) peaks outside window are excluded
// (R09) only peaks above threshold are candidates
// (R10) one threshold for every distance
// (R11) zero maximum jump disables the jump filter
// (R12) large consecutive change activates the filter
// (R13) small change passes the new distance
// (R14) active filter outputs last stable distance
// (R15) return within band releases the filter
// (R16) maximum time elapsed releases the filter
// (R17) timer starts on activation, clears on release
// (R18) no candidate reports no target, keeps filter
module radar_peak_select_jump_filter #(
	parameter int DIST_W      = `RPSJ_DIST_W,
	parameter int AMP_W       = `RPSJ_AMP_W,
	parameter int TIME_W      = `RPSJ_TIME_W,
	parameter int TICK_CYCLES = `RPSJ_TICK_CYCLES
)(
	// clock and reset
	input  wire logic                 mclk,
	input  wire logic                 nrst,
	// peak list from the detector
	input  wire logic                 peakValid,
	input  wire logic [DIST_W-1:0]    peakDist,
	input  wire logic [AMP_W-1:0]     peakAmp,
	input  wire logic                 listEnd,
	// selection settings
	input  wire rpsj_pkg::rpsj_sel_type selMode,
	input  wire logic [AMP_W-1:0]     ampThreshold,
	// measurement window, staged until applied
	input  wire logic [DIST_W-1:0]    rangeMin,
	input  wire logic [DIST_W-1:0]    rangeMax,
	input  wire logic                 rangeApply,
	// jump filter settings
	input  wire logic [DIST_W-1:0]    maxJump,
	input  wire logic [TIME_W-1:0]    maxTime,
	// distance out
	output logic                      distValid,
	output logic [DIST_W-1:0]         distOut,
	output logic                      noTarget,
	output logic                      filterActive,
	// status
	output logic [DIST_W-1:0]         rangeMinActive,
	output logic [DIST_W-1:0]         rangeMaxActive
);

	localparam int RCS_W = AMP_W + 2 * DIST_W;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// cross section estimate: echo amplitude falls with distance squared
	function automatic logic [RCS_W-1:0] rcsEstimate(input logic [AMP_W-1:0] a,
		input logic [DIST_W-1:0] d);
		rcsEstimate = RCS_W'(a) * RCS_W'(d) * RCS_W'(d);
	endfunction

	// true when the candidate beats the best so far in this mode
	function automatic logic betterPeak(input rpsj_pkg::rpsj_sel_type m,
		input logic [DIST_W-1:0] cd, input logic [AMP_W-1:0] ca,
		input logic [RCS_W-1:0] cr, input logic [DIST_W-1:0] bd,
		input logic [AMP_W-1:0] ba, input logic [RCS_W-1:0] br);
		case (m)
			rpsj_pkg::SEL_NEAREST:   betterPeak = cd < bd;   // R01
			rpsj_pkg::SEL_STRONGEST: betterPeak = ca > ba;   // R02
			rpsj_pkg::SEL_RCS_MAX:   betterPeak = cr > br;   // R03
			rpsj_pkg::SEL_FARTHEST:  betterPeak = cd >= bd;  // R04
			rpsj_pkg::SEL_WEAKEST:   betterPeak = ca <= ba;  // R05
			rpsj_pkg::SEL_RCS_MIN:   betterPeak = cr < br;   // R06
			default:                 betterPeak = cd < bd;   // unused codes act as nearest
		endcase
	endfunction

	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic              haveBest;  // a candidate seen in this list
	logic [DIST_W-1:0] bestDist;  // best candidate so far
	logic [AMP_W-1:0]  bestAmp;
	logic [RCS_W-1:0]  bestRcs;
	logic [RCS_W-1:0]  peakRcs;   // estimate of the incoming peak
	logic              inWindow;
	logic              aboveThr;
	logic              candOk;    // incoming peak is a candidate
	logic              takeCand;  // incoming peak becomes the best
	logic              endHave;   // list ends with a target
	logic [DIST_W-1:0] endDist;   // distance chosen at list end

	rpsj_meas_if #(.DIST_W(DIST_W)) meas ();

	// ----------------------------------------
	// measurement window
	// ----------------------------------------
	// staged values are ignored until the apply strobe
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rangeMinActive <= `RPSJ_RANGE_MIN_RST;
			rangeMaxActive <= `RPSJ_RANGE_MAX_RST;
		end else if (rangeApply) begin
			rangeMinActive <= rangeMin;  // R07
			rangeMaxActive <= rangeMax;  // R07
		end
	end

	// ----------------------------------------
	// candidate qualification
	// ----------------------------------------
	assign inWindow = (peakDist >= rangeMinActive) && (peakDist <= rangeMaxActive);  // R08
	// same threshold at every distance, strictly above
	assign aboveThr = peakAmp > ampThreshold;  // R09 R10
	assign candOk   = peakValid && inWindow && aboveThr;
	assign peakRcs  = rcsEstimate(peakAmp, peakDist);
	assign takeCand = candOk && (!haveBest ||
		betterPeak(selMode, peakDist, peakAmp, peakRcs, bestDist, bestAmp, bestRcs));

	// ----------------------------------------
	// running best over the list
	// ----------------------------------------
	// the beat with listEnd is folded in combinationally, then cleared
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			haveBest <= 1'b0;
			bestDist <= '0;
			bestAmp  <= '0;
			bestRcs  <= '0;
		end else if (listEnd) begin
			haveBest <= 1'b0;
		end else if (takeCand) begin
			haveBest <= 1'b1;
			bestDist <= peakDist;
			bestAmp  <= peakAmp;
			bestRcs  <= peakRcs;
		end
	end

	assign endHave = haveBest || candOk;
	assign endDist = takeCand ? peakDist : bestDist;

	// ----------------------------------------
	// result of each measurement cycle
	// ----------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			meas.measValid <= 1'b0;
			meas.measNone  <= 1'b0;
			meas.measDist  <= '0;
		end else begin
			meas.measValid <= listEnd && endHave;
			meas.measNone  <= listEnd && !endHave;  // R18
			if (listEnd && endHave) begin
				meas.measDist <= endDist;
			end
		end
	end

	// ----------------------------------------
	// jump filter
	// ----------------------------------------
	rpsj_jump_filter #(
		.DIST_W      (DIST_W),
		.TIME_W      (TIME_W),
		.TICK_CYCLES (TICK_CYCLES)
	) u_filter (
		.mclk         (mclk),
		.nrst         (nrst),
		.meas         (meas.dst),
		.maxJump      (maxJump),
		.maxTime      (maxTime),
		.distValid    (distValid),
		.distOut      (distOut),
		.noTarget     (noTarget),
		.filterActive (filterActive)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence bestUpdate;
		candOk && haveBest && !listEnd;
	endsequence

	chk_window_apply: assert property (@(posedge mclk) disable iff (!nrst) // R07
		!rangeApply |=> $stable(rangeMinActive) && $stable(rangeMaxActive))
		else $error("window changed without apply");

	chk_window_excl: assert property (@(posedge mclk) disable iff (!nrst) // R08
		peakValid && (peakDist < rangeMinActive || peakDist > rangeMaxActive) |-> !candOk)
		else $error("out-of-window peak accepted");

	chk_thresh_excl: assert property (@(posedge mclk) disable iff (!nrst) // R09
		peakValid && peakAmp <= ampThreshold |-> !candOk && !takeCand)
		else $error("weak peak accepted");

	chk_nearest_best: assert property (@(posedge mclk) disable iff (!nrst) // R01
		bestUpdate and selMode == rpsj_pkg::SEL_NEAREST |=> bestDist <= $past(peakDist))
		else $error("nearest mode kept a farther peak");

	chk_strong_best: assert property (@(posedge mclk) disable iff (!nrst) // R02
		bestUpdate and selMode == rpsj_pkg::SEL_STRONGEST |=> bestAmp >= $past(peakAmp))
		else $error("strongest mode kept a weaker peak");

	chk_farthest_best: assert property (@(posedge mclk) disable iff (!nrst) // R04
		bestUpdate and selMode == rpsj_pkg::SEL_FARTHEST |=> bestDist >= $past(peakDist))
		else $error("farthest mode kept a nearer peak");

	chk_weakest_best: assert property (@(posedge mclk) disable iff (!nrst) // R05
		bestUpdate and selMode == rpsj_pkg::SEL_WEAKEST |=> bestAmp <= $past(peakAmp))
		else $error("weakest mode kept a stronger peak");

	chk_rcs_extreme: assert property (@(posedge mclk) disable iff (!nrst) // R03 R06
		bestUpdate |=> (selMode != rpsj_pkg::SEL_RCS_MAX || bestRcs >= $past(peakRcs)) &&
			(selMode != rpsj_pkg::SEL_RCS_MIN || bestRcs <= $past(peakRcs)))
		else $error("cross section mode kept the wrong peak");

	chk_empty_list: assert property (@(posedge mclk) disable iff (!nrst) // R18
		listEnd && !haveBest && !candOk |=> meas.measNone && !meas.measValid ##1 noTarget)
		else $error("empty list not reported as no target");

endmodule

// ==== verification/rpsj_peak_src.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// upstream peak detector and host window setting
// ----------------------------------------
module rpsj_peak_src (
	// clock
	input  wire logic   mclk,
	// peak stream
	output logic        peakValid,
	output logic [15:0] peakDist,
	output logic [15:0] peakAmp,
	output logic        listEnd,
	// staged window limits
	output logic [15:0] rangeMin,
	output logic [15:0] rangeMax,
	output logic        rangeApply
);
	// idle lines at time zero
	initial begin
		peakValid = 1'b0;
		peakDist = 16'h0000;
		peakAmp = 16'h0000;
		listEnd = 1'b0;
		rangeMin = 16'h0000;
		rangeMax = 16'hFFFF;
		rangeApply = 1'b0;
	end

	// one list, peaks back to back, listEnd on the last beat
	task automatic send(input logic [15:0] d[$], input logic [15:0] a[$]);
		for (int i = 0; i < d.size(); i++) begin
			@(negedge mclk);
			peakValid <= 1'b1;
			peakDist <= d[i];
			peakAmp <= a[i];
			listEnd <= (i == d.size() - 1);
		end
		// empty list: listEnd stands alone
		if (d.size() == 0) begin
			@(negedge mclk);
			listEnd <= 1'b1;
		end
		@(negedge mclk);
		// released lines flip, so a stale peak can never look valid
		peakValid <= 1'b0;
		listEnd <= 1'b0;
		peakDist <= ~peakDist;
		peakAmp <= ~peakAmp;
	endtask

	// stage limits; they only count once the apply pulse is given
	task automatic set_window(input logic [15:0] mn, input logic [15:0] mx, input bit ap);
		@(negedge mclk);
		rangeMin <= mn;
		rangeMax <= mx;
		rangeApply <= ap;
		@(negedge mclk);
		rangeApply <= 1'b0;
	endtask
endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps

module tb_top;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam int TICK = 4;           // short time unit keeps hold tests brief
	logic               mclk;
	logic               nrst;
	logic               peakValid;
	logic [15:0]        peakDist;
	logic [15:0]        peakAmp;
	logic               listEnd;
	rpsj_pkg::rpsj_sel_type selMode;
	logic [15:0]        ampThreshold;
	logic [15:0]        rangeMin;
	logic [15:0]        rangeMax;
	logic               rangeApply;
	logic [15:0]        maxJump;
	logic [15:0]        maxTime;
	logic               distValid;
	logic [15:0]        distOut;
	logic               noTarget;
	logic               filterActive;
	logic [15:0]        rangeMinActive;
	logic [15:0]        rangeMaxActive;
	// reference state
	int                 failures = 0;
	int                 n_tests = 0;
	int                 cyc = 0;
	int                 actCyc = 0;
	int                 fst = 0;     // 0 empty, 1 track, 2 hold
	logic [15:0]        held = 16'h0000;
	logic [15:0]        actMin = 16'h0000;
	logic [15:0]        actMax = 16'hFFFF;
	logic [16:0]        expQ[$];     // bit 16 marks no target
	logic [15:0]        dq[$];
	logic [15:0]        aq[$];

	// ----------------------------------------
	// clock, instances
	// ----------------------------------------
	initial mclk = 1'b0;
	always #2.5 mclk = ~mclk;
	always @(posedge mclk) cyc <= cyc + 1;

	radar_peak_select_jump_filter #(.TICK_CYCLES(TICK)) u_radar_peak_select_jump_filter (
		.mclk(mclk), .nrst(nrst), .peakValid(peakValid), .peakDist(peakDist),
		.peakAmp(peakAmp), .listEnd(listEnd), .selMode(selMode),
		.ampThreshold(ampThreshold), .rangeMin(rangeMin), .rangeMax(rangeMax),
		.rangeApply(rangeApply), .maxJump(maxJump), .maxTime(maxTime),
		.distValid(distValid), .distOut(distOut), .noTarget(noTarget),
		.filterActive(filterActive), .rangeMinActive(rangeMinActive),
		.rangeMaxActive(rangeMaxActive));

	rpsj_peak_src u_rpsj_peak_src (
		.mclk(mclk), .peakValid(peakValid), .peakDist(peakDist), .peakAmp(peakAmp),
		.listEnd(listEnd), .rangeMin(rangeMin), .rangeMax(rangeMax),
		.rangeApply(rangeApply));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_sim();
		if (failures == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// candidate pick; earlier peak wins ties except farthest and weakest
	function automatic logic [16:0] pick();
		logic [16:0] b;
		logic [15:0] ba;
		logic [63:0] r;
		logic [63:0] br;
		logic        take;
		b = '0;
		ba = '0;
		br = '0;
		foreach (dq[i]) begin
			r = 64'(aq[i]) * dq[i] * dq[i];
			if (dq[i] >= actMin && dq[i] <= actMax && aq[i] > ampThreshold) begin
				case (selMode)
					rpsj_pkg::SEL_STRONGEST: take = aq[i] > ba;
					rpsj_pkg::SEL_RCS_MAX: take = r > br;
					rpsj_pkg::SEL_FARTHEST: take = dq[i] >= b[15:0];
					rpsj_pkg::SEL_WEAKEST: take = aq[i] <= ba;
					rpsj_pkg::SEL_RCS_MIN: take = r < br;
					default: take = dq[i] < b[15:0];
				endcase
				if (!b[16] || take) begin
					b = {1'b1, dq[i]};
					ba = aq[i];
					br = r;
				end
			end
		end
		return b;
	endfunction

	// send the staged list and note the expected output
	task automatic measure();
		logic [16:0] s;
		logic [15:0] df;
		logic        rel;
		u_rpsj_peak_src.send(dq, aq);
		// let the filter take this result before filter settings may change
		@(negedge mclk);
		s = pick();
		if (!s[16]) begin
			expQ.push_back(17'h1_0000);
		end else begin
			df = (s[15:0] > held) ? s[15:0] - held : held - s[15:0];
			if (fst == 2) begin
				rel = maxJump == 0 || df <= maxJump || (maxTime != 0 && cyc - actCyc >= maxTime * TICK);
			end else begin
				rel = fst == 0 || maxJump == 0 || df <= maxJump;
			end
			if (rel) begin
				held = s[15:0];
				fst = 1;
			end else if (fst == 1) begin
				fst = 2;
				actCyc = cyc;
			end
			expQ.push_back({1'b0, held});
		end
	endtask

	task automatic win(input logic [15:0] mn, input logic [15:0] mx, input bit ap);
		u_rpsj_peak_src.set_window(mn, mx, ap);
		if (ap) begin
			actMin = mn;
			actMax = mx;
		end
	endtask

	task automatic one(input logic [15:0] d);
		dq = '{d};
		aq = '{16'h0064};
		measure();
	endtask

	// ----------------------------------------
	// output watcher: oldest note against each result
	// ----------------------------------------
	always @(negedge mclk) begin
		if (nrst && (distValid === 1'b1 || noTarget === 1'b1)) begin
			if (expQ.size() == 0) begin
				chk({15'h0, noTarget, distOut}, 32'hFFFF_FFFF);
			end else begin
				chk({15'h0, noTarget, noTarget ? 16'h0000 : distOut}, {15'h0, expQ.pop_front()});
			end
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		nrst = 1'b0;
		selMode = rpsj_pkg::SEL_NEAREST;
		ampThreshold = 16'h0028;
		maxJump = 16'h0000;
		maxTime = 16'h0000;
		void'($urandom(82));
		repeat (16) @(negedge mclk);
		nrst <= 1'b1;
		chk({rangeMinActive, rangeMaxActive}, 32'h0000_FFFF);
		win(16'd100, 16'd900, 1'b1);
		// every mode: boundary list, then random lists, filter bypassed
		for (int m = 0; m < 6; m++) begin
			selMode <= rpsj_pkg::rpsj_sel_type'(m);
			dq = '{16'd100, 16'd99, 16'd900, 16'd901, 16'd500, 16'd300};
			aq = '{16'd41, 16'd200, 16'd41, 16'd200, 16'd40, 16'd41};
			measure();
			repeat (6) begin
				dq = {};
				aq = {};
				repeat ($urandom_range(1, 5)) begin
					dq.push_back(16'($urandom_range(0, 1000)));
					aq.push_back(16'($urandom_range(0, 255)));
				end
				measure();
			end
		end
		selMode <= rpsj_pkg::SEL_NEAREST;
		dq = {};
		aq = {};
		measure();
		// staged limits stay inert until applied
		win(16'd300, 16'd900, 1'b0);
		one(16'd200);
		chk(32'(rangeMinActive), 32'd100);
		win(16'd300, 16'd900, 1'b1);
		one(16'd200);
		chk({rangeMinActive, rangeMaxActive}, 32'h012C_0384);
		// jump filter
		win(16'h0000, 16'hFFFF, 1'b1);
		one(16'd500);
		maxJump <= 16'd50;
		maxTime <= 16'd4;
		one(16'd530);
		one(16'd700);
		dq = {};
		aq = {};
		measure();
		one(16'd710);
		one(16'd560);
		one(16'd800);
		repeat (3) @(negedge mclk);
		chk(32'(filterActive), 32'd1);
		repeat (40) @(negedge mclk);
		one(16'd810);
		one(16'd820);
		one(16'd900);
		one(16'd905);
		maxJump <= 16'd0;
		one(16'd2000);
		for (int k = 0; k < 100 && expQ.size() > 0; k++) begin
			@(negedge mclk);
		end
		if (expQ.size() > 0) begin
			failures++;
		end
		end_sim();
	end
endmodule
